// ===== redriver_defs.svh
`ifndef REDRIVER_DEFS_SVH
`define REDRIVER_DEFS_SVH

// ************************************************************
// Channel register offsets
// ************************************************************
`define OFS_STATUS 8'h00
`define OFS_EQ 8'h01
`define OFS_PROF 8'h03
`define OFS_DET 8'h04
`define OFS_ID 8'h07

// ************************************************************
// Field positions
// ************************************************************
`define ST_TERM_P_BIT 7
`define ST_TERM_N_BIT 6
`define EQ_SKIP_BIT 7
`define EQ_B1_HI 6
`define EQ_B1_LO 3
`define EQ_B2_HI 2
`define EQ_B2_LO 0
`define PROF_HI 6
`define PROF_LO 3
`define FLAT_HI 2
`define FLAT_LO 0
`define DET_FORCE_BIT 2
`define DET_EN_BIT 1
`define DET_SEL_BIT 0

// ************************************************************
// Reset values and counts
// ************************************************************
`define B1_RST 4'h0
`define B2_RST 3'h0
`define PROF_RST 4'h0
`define FLAT_RST 3'h5
`define PTR_RST 8'h00
`define PTR_STEP 8'h01
`define BYTE_BITS 4'h8
`define BIT_STEP 4'h1
`define POLLS_SINGLE 2'h1
`define POLLS_TWO 2'h2
`define POLLS_THREE 2'h3
`define POLL_STEP 2'h1

// ************************************************************
// Bus address and identity
// ************************************************************
`define DEV_ADDR_DEFAULT 7'h18
// Arbitrary identity value
`define ID_CODE_DEFAULT 8'h5a

`endif

// ===== redriver_pkg.sv
`default_nettype none
package redriver_pkg;

	// Equalizer settings handed to the analog datapath
	typedef struct packed {
		logic first_stage_skip;
		logic [3:0] first_stage_boost;
		logic [2:0] second_stage_boost;
		logic [3:0] midband_profile;
		logic [2:0] flat_gain;
	} eq_ctrl_t;

	// Receiver-detect controls
	typedef struct packed {
		logic termination_detect_force;
		logic poll_extra_en;
		logic poll_three_sel;
	} det_ctrl_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ADDR = 4'h1,
		ST_ADDR_ACK = 4'h3,
		ST_PTR = 4'h2,
		ST_PTR_ACK = 4'h6,
		ST_WDATA = 4'h7,
		ST_WDATA_ACK = 4'h5,
		ST_RDATA = 4'h4,
		ST_RDATA_ACK = 4'hc
	} smb_state_t;

	typedef enum logic [1:0] {
		DET_IDLE = 2'h0,
		DET_POLL = 2'h1,
		DET_DONE = 2'h3
	} det_state_t;

endpackage : redriver_pkg
`default_nettype wire

// ===== pin_sync3.sv
`timescale 1ns/1ns
`default_nettype none
`include "redriver_defs.svh"

module pin_sync3 #(
	parameter int W = 2
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Asynchronous pins and their settled levels
	input wire logic [W-1:0] i_pin,
	output logic [W-1:0] o_level
);

	logic [W-1:0] meta_r;
	logic [W-1:0] mid_r;
	logic [W-1:0] late_r;
	logic [W-1:0] level_r;
	wire logic [W-1:0] agree;

	// Only the second and third stages are compared; the first may be metastable
	assign agree = ~(mid_r ^ late_r);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta_r <= '1;
			mid_r <= '1;
			late_r <= '1;
			level_r <= '1;
		end else begin
			meta_r <= i_pin;
			mid_r <= meta_r;
			late_r <= mid_r;
			level_r <= (late_r & agree) | (level_r & ~agree);
		end
	end

	assign o_level = level_r;

endmodule : pin_sync3
`default_nettype wire

// ===== rx_detect_poll.sv
`timescale 1ns/1ns
`default_nettype none
`include "redriver_defs.svh"

module rx_detect_poll (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Controls from the register bank
	input wire redriver_pkg::det_ctrl_t i_ctrl,
	// Comparator results, valid when i_poll is high
	input wire logic i_poll,
	input wire logic i_hit_p,
	input wire logic i_hit_n,
	// Latched results and live polling status
	output logic o_term_p,
	output logic o_term_n,
	output logic o_polling
);

	redriver_pkg::det_state_t state_r;
	redriver_pkg::det_state_t state_nxt;
	logic [1:0] cnt_p_r;
	logic [1:0] cnt_n_r;
	logic term_p_r;
	logic term_n_r;
	logic polling_r;

	function automatic logic [1:0] polls_needed(input redriver_pkg::det_ctrl_t c);
		if (!c.poll_extra_en) begin
			polls_needed = `POLLS_SINGLE;
		end else begin
			polls_needed = c.poll_three_sel ? `POLLS_THREE : `POLLS_TWO;
		end
	endfunction : polls_needed

	function automatic logic [1:0] next_count(input logic hit, input logic [1:0] cnt);
		next_count = hit ? cnt + `POLL_STEP : 2'h0;
	endfunction : next_count

	wire logic [1:0] need = polls_needed(i_ctrl);
	wire logic poll_now = (state_r == redriver_pkg::DET_POLL) && i_poll;
	wire logic [1:0] cnt_p_nxt = next_count(i_hit_p, cnt_p_r);
	wire logic [1:0] cnt_n_nxt = next_count(i_hit_n, cnt_n_r);
	wire logic reach_p = poll_now && i_hit_p && (cnt_p_nxt >= need);
	wire logic reach_n = poll_now && i_hit_n && (cnt_n_nxt >= need);
	wire logic force_det = i_ctrl.termination_detect_force;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			redriver_pkg::DET_IDLE: state_nxt = redriver_pkg::DET_POLL;
			redriver_pkg::DET_POLL: begin
				// Stop polling once both pins have their run of detections
				if (force_det || ((term_p_r || reach_p) && (term_n_r || reach_n))) begin
					state_nxt = redriver_pkg::DET_DONE;
				end
			end
			redriver_pkg::DET_DONE: state_nxt = redriver_pkg::DET_DONE;
			default: state_nxt = redriver_pkg::DET_IDLE;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_r <= redriver_pkg::DET_IDLE;
			cnt_p_r <= 2'h0;
			cnt_n_r <= 2'h0;
			term_p_r <= 1'b0;
			term_n_r <= 1'b0;
			polling_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (poll_now) begin
				cnt_p_r <= cnt_p_nxt;
				cnt_n_r <= cnt_n_nxt;
			end
			// Results latch; only reset clears them
			term_p_r <= term_p_r | reach_p | force_det;
			term_n_r <= term_n_r | reach_n | force_det;
			polling_r <= (state_nxt == redriver_pkg::DET_POLL) && !force_det;
		end
	end

	assign o_term_p = term_p_r;
	assign o_term_n = term_n_r;
	assign o_polling = polling_r;

	chk_term_p_latched: assert property (@(posedge i_clk) disable iff (i_rst)
		term_p_r |=> term_p_r)
		else $error("positive pin detection dropped");
	chk_term_n_latched: assert property (@(posedge i_clk) disable iff (i_rst)
		term_n_r |=> term_n_r)
		else $error("negative pin detection dropped");
	chk_force_detects: assert property (@(posedge i_clk) disable iff (i_rst)
		force_det |=> (term_p_r && term_n_r && !polling_r))
		else $error("forced detection not reported");
	chk_single_poll: assert property (@(posedge i_clk) disable iff (i_rst)
		(poll_now && !i_ctrl.poll_extra_en && i_hit_p) |=> term_p_r)
		else $error("single detection not latched");
	chk_three_polls: assert property (@(posedge i_clk) disable iff (i_rst)
		(poll_now && i_ctrl.poll_extra_en && i_ctrl.poll_three_sel && !force_det
		&& !term_p_r && i_hit_p && cnt_p_r == 2'h1) |=> !term_p_r)
		else $error("latched after two of three detections");
	chk_two_polls: assert property (@(posedge i_clk) disable iff (i_rst)
		(poll_now && i_ctrl.poll_extra_en && !i_ctrl.poll_three_sel
		&& i_hit_n && cnt_n_r == 2'h1) |=> term_n_r)
		else $error("two detections not latched");

endmodule : rx_detect_poll
`default_nettype wire

// ===== redriver_channel_control_regs.sv
// Summary of operation
// - Status bit 7 reports a termination detected on the positive pin and stays set once set.
// - Status bit 6 reports a termination detected on the negative pin, latched, zero meaning none.
// - Bit 7 of the gain register at 0x01 skips the first equalizer stage when one, reset zero.
// - Bits 6 to 3 of the gain register hold the first-stage boost, read-write, reset zero.
// - Bits 2 to 0 of the gain register hold the second-stage boost, read-write, reset zero.
// - Register 0x03 holds a mid-band profile in bits 6 to 3, reset zero, with bit 7 read-only.
// - Bits 2 to 0 of register 0x03 hold the flat gain, read-write, resetting to binary 101.
// - Bit 2 of register 0x04 bypasses the detect machine and reports termination as detected.
// - Bit 1 of register 0x04 enables additional detect polling, reset zero.
// - With polling enabled, bit 0 picks two (zero) or three (one) consecutive detections.
`timescale 1ns/1ns
`default_nettype none
`include "redriver_defs.svh"

module redriver_channel_control_regs #(
	parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT,
	// Arbitrary identity value
	parameter logic [7:0] ID_CODE = `ID_CODE_DEFAULT
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Two-wire management bus
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	// Detect comparator
	input wire logic i_poll,
	input wire logic i_hit_p,
	input wire logic i_hit_n,
	// Datapath controls and detect results
	output redriver_pkg::eq_ctrl_t o_eq,
	output logic o_term_p,
	output logic o_term_n,
	output logic o_polling
);

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic [1:0] pins_level;
	logic scl_q_r;
	logic sda_q_r;

	pin_sync3 #(
		.W(2)
	) u_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_pin({i_scl, i_sda}),
		.o_level(pins_level)
	);

	wire logic scl_s = pins_level[1];
	wire logic sda_s = pins_level[0];
	wire logic scl_rise = scl_s && !scl_q_r;
	wire logic scl_fall = !scl_s && scl_q_r;
	wire logic bus_start = scl_s && scl_q_r && sda_q_r && !sda_s;
	wire logic bus_stop = scl_s && scl_q_r && !sda_q_r && sda_s;

	// ************************************************************
	// Bus target state
	// ************************************************************
	redriver_pkg::smb_state_t state_r;
	logic [3:0] cnt_r;
	logic [7:0] shift_r;
	logic [7:0] tx_r;
	logic [7:0] ptr_r;
	logic rw_r;
	logic nack_r;
	logic sda_oe_r;
	logic sda_out_r;

	// ************************************************************
	// Register storage
	// ************************************************************
	redriver_pkg::eq_ctrl_t eq_r;
	redriver_pkg::det_ctrl_t det_r;
	logic term_p;
	logic term_n;

	function automatic logic [7:0] read_byte(
		input logic [7:0] ofs,
		input logic tp,
		input logic tn,
		input redriver_pkg::eq_ctrl_t eq,
		input redriver_pkg::det_ctrl_t det,
		input logic [7:0] id
	);
		read_byte = 8'h00;
		// Reserved bits and unmapped offsets stay zero
		if (ofs == `OFS_STATUS) begin
			read_byte[`ST_TERM_P_BIT] = tp;
			read_byte[`ST_TERM_N_BIT] = tn;
		end else if (ofs == `OFS_EQ) begin
			read_byte[`EQ_SKIP_BIT] = eq.first_stage_skip;
			read_byte[`EQ_B1_HI:`EQ_B1_LO] = eq.first_stage_boost;
			read_byte[`EQ_B2_HI:`EQ_B2_LO] = eq.second_stage_boost;
		end else if (ofs == `OFS_PROF) begin
			read_byte[`PROF_HI:`PROF_LO] = eq.midband_profile;
			read_byte[`FLAT_HI:`FLAT_LO] = eq.flat_gain;
		end else if (ofs == `OFS_DET) begin
			read_byte[`DET_FORCE_BIT] = det.termination_detect_force;
			read_byte[`DET_EN_BIT] = det.poll_extra_en;
			read_byte[`DET_SEL_BIT] = det.poll_three_sel;
		end else if (ofs == `OFS_ID) begin
			read_byte = id;
		end
	endfunction : read_byte

	wire logic [7:0] rd_data = read_byte(ptr_r, term_p, term_n, eq_r, det_r, ID_CODE);
	wire logic byte_done = scl_fall && (cnt_r == `BYTE_BITS);
	wire logic addr_match = (shift_r[7:1] == DEV_ADDR);
	wire logic wr_fire = (state_r == redriver_pkg::ST_WDATA) && byte_done && !bus_start;
	wire logic wr_eq = wr_fire && (ptr_r == `OFS_EQ);
	wire logic wr_prof = wr_fire && (ptr_r == `OFS_PROF);
	wire logic wr_det = wr_fire && (ptr_r == `OFS_DET);
	wire logic [7:0] ptr_inc = ptr_r + `PTR_STEP;

	// ************************************************************
	// Bus target sequencing
	// ************************************************************
	// Start and stop win over everything so a confused host can always resync
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
			state_r <= redriver_pkg::ST_IDLE;
			cnt_r <= 4'h0;
			shift_r <= 8'h00;
			tx_r <= 8'h00;
			ptr_r <= `PTR_RST;
			rw_r <= 1'b0;
			nack_r <= 1'b0;
			sda_oe_r <= 1'b0;
			sda_out_r <= 1'b0;
		end else begin
			scl_q_r <= scl_s;
			sda_q_r <= sda_s;
			// Open drain: the pin is only ever pulled low
			sda_out_r <= 1'b0;
			if (scl_rise) begin
				shift_r <= {shift_r[6:0], sda_s};
				cnt_r <= cnt_r + `BIT_STEP;
				nack_r <= sda_s;
			end
			if (bus_start) begin
				state_r <= redriver_pkg::ST_ADDR;
				cnt_r <= 4'h0;
				sda_oe_r <= 1'b0;
			end else if (bus_stop) begin
				state_r <= redriver_pkg::ST_IDLE;
				sda_oe_r <= 1'b0;
			end else if (scl_fall) begin
				unique case (state_r)
					redriver_pkg::ST_IDLE: begin
						sda_oe_r <= 1'b0;
					end
					redriver_pkg::ST_ADDR: begin
						if (byte_done && addr_match) begin
							rw_r <= shift_r[0];
							sda_oe_r <= 1'b1;
							state_r <= redriver_pkg::ST_ADDR_ACK;
						end else if (byte_done) begin
							state_r <= redriver_pkg::ST_IDLE;
						end
					end
					redriver_pkg::ST_ADDR_ACK: begin
						cnt_r <= 4'h0;
						if (rw_r) begin
							tx_r <= rd_data;
							sda_oe_r <= !rd_data[7];
							state_r <= redriver_pkg::ST_RDATA;
						end else begin
							sda_oe_r <= 1'b0;
							state_r <= redriver_pkg::ST_PTR;
						end
					end
					redriver_pkg::ST_PTR: begin
						if (byte_done) begin
							ptr_r <= shift_r;
							sda_oe_r <= 1'b1;
							state_r <= redriver_pkg::ST_PTR_ACK;
						end
					end
					redriver_pkg::ST_PTR_ACK: begin
						cnt_r <= 4'h0;
						sda_oe_r <= 1'b0;
						state_r <= redriver_pkg::ST_WDATA;
					end
					redriver_pkg::ST_WDATA: begin
						// Every byte is acknowledged, even to read-only offsets
						if (byte_done) begin
							sda_oe_r <= 1'b1;
							state_r <= redriver_pkg::ST_WDATA_ACK;
						end
					end
					redriver_pkg::ST_WDATA_ACK: begin
						cnt_r <= 4'h0;
						ptr_r <= ptr_inc;
						sda_oe_r <= 1'b0;
						state_r <= redriver_pkg::ST_WDATA;
					end
					redriver_pkg::ST_RDATA: begin
						if (byte_done) begin
							sda_oe_r <= 1'b0;
							ptr_r <= ptr_inc;
							state_r <= redriver_pkg::ST_RDATA_ACK;
						end else begin
							tx_r <= {tx_r[6:0], 1'b0};
							sda_oe_r <= !tx_r[6];
						end
					end
					redriver_pkg::ST_RDATA_ACK: begin
						cnt_r <= 4'h0;
						if (nack_r) begin
							state_r <= redriver_pkg::ST_IDLE;
						end else begin
							tx_r <= rd_data;
							sda_oe_r <= !rd_data[7];
							state_r <= redriver_pkg::ST_RDATA;
						end
					end
					default: begin
						sda_oe_r <= 1'b0;
						state_r <= redriver_pkg::ST_IDLE;
					end
				endcase
			end
		end
	end

	// ************************************************************
	// Register writes
	// ************************************************************
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			eq_r.first_stage_skip <= 1'b0;
			eq_r.first_stage_boost <= `B1_RST;
			eq_r.second_stage_boost <= `B2_RST;
			eq_r.midband_profile <= `PROF_RST;
			eq_r.flat_gain <= `FLAT_RST;
			det_r <= '0;
		end else begin
			if (wr_eq) begin
				eq_r.first_stage_skip <= shift_r[`EQ_SKIP_BIT];
				eq_r.first_stage_boost <= shift_r[`EQ_B1_HI:`EQ_B1_LO];
				eq_r.second_stage_boost <= shift_r[`EQ_B2_HI:`EQ_B2_LO];
			end
			// Bit 7 here and bits 7 to 3 of the detect register are dropped
			if (wr_prof) begin
				eq_r.midband_profile <= shift_r[`PROF_HI:`PROF_LO];
				eq_r.flat_gain <= shift_r[`FLAT_HI:`FLAT_LO];
			end
			if (wr_det) begin
				det_r.termination_detect_force <= shift_r[`DET_FORCE_BIT];
				det_r.poll_extra_en <= shift_r[`DET_EN_BIT];
				det_r.poll_three_sel <= shift_r[`DET_SEL_BIT];
			end
		end
	end

	// ************************************************************
	// Receiver detect
	// ************************************************************
	rx_detect_poll u_detect (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_ctrl(det_r),
		.i_poll(i_poll),
		.i_hit_p(i_hit_p),
		.i_hit_n(i_hit_n),
		.o_term_p(term_p),
		.o_term_n(term_n),
		.o_polling(o_polling)
	);

	assign o_term_p = term_p;
	assign o_term_n = term_n;
	assign o_eq = eq_r;
	assign o_sda_out = sda_out_r;
	assign o_sda_oe = sda_oe_r;

	// ************************************************************
	// Checks
	// ************************************************************
	chk_skip_write: assert property (@(posedge i_clk) disable iff (i_rst)
		wr_eq |=> (eq_r.first_stage_skip == $past(shift_r[`EQ_SKIP_BIT])))
		else $error("stage one skip not written");
	chk_boost1_write: assert property (@(posedge i_clk) disable iff (i_rst)
		wr_eq |=> (eq_r.first_stage_boost == $past(shift_r[`EQ_B1_HI:`EQ_B1_LO])))
		else $error("stage one boost not written");
	chk_boost2_hold: assert property (@(posedge i_clk) disable iff (i_rst)
		!wr_eq |=> $stable(eq_r.second_stage_boost))
		else $error("stage two boost changed without a write");
	chk_profile_reserved: assert property (@(posedge i_clk) disable iff (i_rst)
		(ptr_r == `OFS_PROF) |-> (rd_data[7] == 1'b0))
		else $error("reserved profile bit reads nonzero");
	chk_flat_reset: assert property (@(posedge i_clk)
		i_rst |=> (eq_r.flat_gain == `FLAT_RST && eq_r.midband_profile == `PROF_RST))
		else $error("flat gain reset value wrong");
	chk_status_low_zero: assert property (@(posedge i_clk) disable iff (i_rst)
		(ptr_r == `OFS_STATUS || ptr_r == `OFS_DET) |-> (rd_data[5:3] == 3'h0))
		else $error("reserved bits read nonzero");
	chk_term_readback: assert property (@(posedge i_clk) disable iff (i_rst)
		(ptr_r == `OFS_STATUS) |-> (rd_data[`ST_TERM_P_BIT] == term_p
		&& rd_data[`ST_TERM_N_BIT] == term_n))
		else $error("status does not show detect results");
	chk_force_write: assert property (@(posedge i_clk) disable iff (i_rst)
		(wr_det && shift_r[`DET_FORCE_BIT]) |-> ##2 (term_p && term_n))
		else $error("forced detect not visible in status");

endmodule : redriver_channel_control_regs
`default_nettype wire

// ===== redriver_bus_host.sv
`timescale 1ns/1ns
`default_nettype none
`include "redriver_defs.svh"

module redriver_bus_host #(
	parameter logic [6:0] TARGET = `DEV_ADDR_DEFAULT
) (
	// Clock
	input wire logic i_clk,
	// Bus lines, data seen as the resolved wire
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_pull
);
	// ************************************************************
	// Bit timing
	// ************************************************************
	// Ten-cycle phases leave margin over the target's synchroniser delay
	localparam int PHASE = 10;

	initial begin
		o_scl = 1'b1;
		o_sda_pull = 1'b0;
	end

	task automatic w(input int n);
		repeat (n) @(negedge i_clk);
	endtask : w

	// Data changes mid low phase so both setup and hold are kept
	task automatic low_phase(input logic pull);
		o_scl = 1'b0;
		w(PHASE / 2);
		o_sda_pull = pull;
		w(PHASE / 2);
		o_scl = 1'b1;
		w(PHASE);
	endtask : low_phase

	task automatic start_cond();
		low_phase(1'b0);
		o_sda_pull = 1'b1;
		w(PHASE);
	endtask : start_cond

	task automatic stop_cond();
		low_phase(1'b1);
		o_sda_pull = 1'b0;
		w(PHASE);
	endtask : stop_cond

	// ************************************************************
	// Byte and register transfers
	// ************************************************************
	task automatic send_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			low_phase(~b[i]);
		end
		low_phase(1'b0);
		ack = ~i_sda;
	endtask : send_byte

	task automatic recv_byte(input logic nack, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			low_phase(1'b0);
			d[i] = i_sda;
		end
		// A not-acknowledge leaves the line released for the pull-up
		low_phase(~nack);
	endtask : recv_byte

	task automatic probe(input logic [6:0] addr, output logic ack);
		start_cond();
		send_byte({addr, 1'b0}, ack);
		stop_cond();
	endtask : probe

	task automatic write_reg(input logic [7:0] ofs, input logic [7:0] data, output logic ok);
		logic a0, a1, a2;
		start_cond();
		send_byte({TARGET, 1'b0}, a0);
		send_byte(ofs, a1);
		send_byte(data, a2);
		stop_cond();
		ok = a0 & a1 & a2;
	endtask : write_reg

	task automatic read_reg(input logic [7:0] ofs, output logic [7:0] data, output logic ok);
		logic a0, a1, a2;
		start_cond();
		send_byte({TARGET, 1'b0}, a0);
		send_byte(ofs, a1);
		start_cond();
		send_byte({TARGET, 1'b1}, a2);
		recv_byte(1'b1, data);
		stop_cond();
		ok = a0 & a1 & a2;
	endtask : read_reg
endmodule : redriver_bus_host
`default_nettype wire

// ===== redriver_channel_control_regs_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "redriver_defs.svh"

module redriver_channel_control_regs_test;
	logic i_clk, i_rst, i_poll, i_hit_p, i_hit_n, scl, pull, ok, o_sda_out, o_sda_oe;
	logic o_term_p, o_term_n, o_polling;
	logic [7:0] ctl;
	redriver_pkg::eq_ctrl_t o_eq;
	wire logic sda_line;
	int n_errors, compares, cnt;

	// Pull-up wire: low when either party pulls
	assign sda_line = ~(pull | o_sda_oe);

	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	redriver_channel_control_regs #(.DEV_ADDR(`DEV_ADDR_DEFAULT)) u_redriver_channel_control_regs (
		.i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda_line), .o_sda_out(o_sda_out),
		.o_sda_oe(o_sda_oe), .i_poll(i_poll), .i_hit_p(i_hit_p), .i_hit_n(i_hit_n),
		.o_eq(o_eq), .o_term_p(o_term_p), .o_term_n(o_term_n), .o_polling(o_polling));

	redriver_bus_host #(.TARGET(`DEV_ADDR_DEFAULT)) u_redriver_bus_host (
		.i_clk(i_clk), .i_sda(sda_line), .o_scl(scl), .o_sda_pull(pull));

	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
		u_redriver_bus_host.write_reg(ofs, d, ok);
		chk("write ack", 16'h0001, {15'h0000, ok});
	endtask : wr

	task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
		logic [7:0] d;
		u_redriver_bus_host.read_reg(ofs, d, ok);
		chk("read ack", 16'h0001, {15'h0000, ok});
		chk($sformatf("register %h", ofs), {8'h00, exp}, {8'h00, d});
	endtask : rd

	task automatic do_reset();
		@(negedge i_clk);
		i_rst = 1'b1;
		repeat (3) @(negedge i_clk);
		i_rst = 1'b0;
		repeat (5) @(negedge i_clk);
	endtask : do_reset

	task automatic poll(input logic p, input logic n);
		@(negedge i_clk);
		i_poll = 1'b1;
		i_hit_p = p;
		i_hit_n = n;
		@(negedge i_clk);
		i_poll = 1'b0;
		i_hit_p = 1'b0;
		i_hit_n = 1'b0;
		@(negedge i_clk);
	endtask : poll

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : give_verdict

	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		i_rst = 1'b1;
		i_poll = 1'b0;
		i_hit_p = 1'b0;
		i_hit_n = 1'b0;
		n_errors = 0;
		compares = 0;
		do_reset();
		chk("eq after reset", 16'h0005, {1'b0, o_eq});
		chk("sda out level", 16'h0000, {15'h0000, o_sda_out});
		rd(`OFS_EQ, 8'h00);
		rd(`OFS_PROF, 8'h05);
		rd(`OFS_DET, 8'h00);
		rd(`OFS_STATUS, 8'h00);
		$display("Test reset values done");
		wr(`OFS_EQ, 8'hff);
		rd(`OFS_EQ, 8'hff);
		chk("eq all set", 16'h7f85, {1'b0, o_eq});
		wr(`OFS_EQ, 8'h4a);
		rd(`OFS_EQ, 8'h4a);
		chk("eq pattern", 16'h2505, {1'b0, o_eq});
		wr(`OFS_PROF, 8'hff);
		rd(`OFS_PROF, 8'h7f);
		wr(`OFS_PROF, 8'h32);
		rd(`OFS_PROF, 8'h32);
		chk("profile and flat", 16'h2532, {1'b0, o_eq});
		$display("Test equalizer registers done");
		wr(`OFS_STATUS, 8'hff);
		rd(`OFS_STATUS, 8'h00);
		rd(8'h02, 8'h00);
		wr(`OFS_ID, 8'h00);
		rd(`OFS_ID, `ID_CODE_DEFAULT);
		u_redriver_bus_host.probe(`DEV_ADDR_DEFAULT ^ 7'h01, ok);
		chk("foreign address ack", 16'h0000, {15'h0000, ok});
		$display("Test read-only and unmapped done");
		// Results latch until reset, so each polling mode starts fresh
		for (int m = 0; m < 3; m++) begin
			do_reset();
			cnt = m + 1;
			ctl = (m == 0) ? 8'h00 : ((m == 1) ? 8'h02 : 8'h03);
			wr(`OFS_DET, ctl);
			rd(`OFS_DET, ctl);
			chk("polling active", 16'h0001, {15'h0000, o_polling});
			repeat (cnt - 1) poll(1'b1, 1'b0);
			poll(1'b0, 1'b0);
			repeat (cnt - 1) poll(1'b1, 1'b0);
			chk("positive early", 16'h0000, {15'h0000, o_term_p});
			poll(1'b1, 1'b0);
			chk("positive detected", 16'h0001, {15'h0000, o_term_p});
			chk("negative idle", 16'h0000, {15'h0000, o_term_n});
			repeat (cnt) poll(1'b0, 1'b1);
			poll(1'b0, 1'b0);
			chk("positive held", 16'h0001, {15'h0000, o_term_p});
			chk("negative detected", 16'h0001, {15'h0000, o_term_n});
			chk("polling stopped", 16'h0000, {15'h0000, o_polling});
			rd(`OFS_STATUS, 8'hc0);
		end
		$display("Test detect counts done");
		do_reset();
		wr(`OFS_DET, 8'hff);
		chk("forced positive", 16'h0001, {15'h0000, o_term_p});
		chk("forced negative", 16'h0001, {15'h0000, o_term_n});
		chk("forced polling", 16'h0000, {15'h0000, o_polling});
		rd(`OFS_DET, 8'h07);
		rd(`OFS_STATUS, 8'hc0);
		$display("Test detect override done");
		give_verdict();
	end

	// ************************************************************
	// Watchdog
	// ************************************************************
	initial begin
		repeat (60000) @(posedge i_clk);
		n_errors++;
		$display("ERROR watchdog expected finish seen timeout");
		give_verdict();
	end
endmodule : redriver_channel_control_regs_test
`default_nettype wire
